//--- hw/tpwm_cfg.svh
// Constants of the eight-bit PWM timer: offsets, field positions, reset values, codes.
// Assumes inclusion by bare name from the package and the top module.
`ifndef TPWM_CFG_SVH
`define TPWM_CFG_SVH

`define TPWM_OFS_CTRL      12'h000
`define TPWM_OFS_COUNT     12'h004
`define TPWM_OFS_CMP       12'h008
`define TPWM_OFS_FLAGS     12'h00C
`define TPWM_OFS_ACTIVE    12'h010

`define TPWM_CTRL_WGM_LSB  0
`define TPWM_CTRL_COM_LSB  4
`define TPWM_CTRL_CS_LSB   8
`define TPWM_FLAG_OVF_BIT  0
`define TPWM_FLAG_CMP_BIT  1
`define TPWM_ACT_DIR_BIT   8

`define TPWM_MAX           8'hFF
`define TPWM_BOTTOM        8'h00

`define TPWM_WGM_NORMAL    2'h0
`define TPWM_WGM_PCPWM     2'h1
`define TPWM_WGM_CTC       2'h2
`define TPWM_WGM_FAST      2'h3

`define TPWM_COM_OFF       2'h0
`define TPWM_COM_TOGGLE    2'h1
`define TPWM_COM_CLEAR     2'h2
`define TPWM_COM_SET       2'h3

`define TPWM_CS_STOP       3'h0
`define TPWM_PSC_MASK_1    10'h000
`define TPWM_PSC_MASK_8    10'h007
`define TPWM_PSC_MASK_32   10'h01F
`define TPWM_PSC_MASK_64   10'h03F
`define TPWM_PSC_MASK_128  10'h07F
`define TPWM_PSC_MASK_256  10'h0FF
`define TPWM_PSC_MASK_1024 10'h3FF

`define TPWM_WGM_RST       2'h0
`define TPWM_COM_RST       2'h0
`define TPWM_CS_RST        3'h0
`define TPWM_COUNT_RST     8'h00
`define TPWM_CMP_RST       8'h00
`define TPWM_PSC_RST       10'h000

`endif

//--- hw/tpwm_pkg.sv
// Types of the eight-bit PWM timer.
// Assumes the constants header is on the include path.
`include "tpwm_cfg.svh"

package tpwm_pkg;

  typedef enum logic {
    dir_up,
    dir_down
  } tpwm_dir_type;

  typedef logic [7:0] tpwm_count_type;

endpackage : tpwm_pkg

//--- hw/tpwm_top.sv
// Eight-bit timer with fast and phase correct PWM waveform generation and an APB slave.
// Assumes one clock, a synchronous active-high reset and an APB master on the same clock.
//
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`include "tpwm_cfg.svh"

module tpwm_top
  import tpwm_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              clk_sys_in,
  input  wire logic              rst_in,
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [ADDR_W-1:0] paddr_in,
  input  wire logic [31:0]       pwdata_in,
  input  wire logic [3:0]        pstrb_in,
  output logic      [31:0]       prdata_out,
  output logic                   pready_out,
  output logic                   pslverr_out,
  output logic                   compare_output_out,
  output logic                   compare_output_en_out,
  output logic                   overflow_flag_out,
  output logic                   compare_match_flag_out,
  output logic      [7:0]        counter_value_out
);

  // Control and state registers.
  logic [1:0]     waveform_mode_sel;
  logic [1:0]     compare_output_mode;
  logic [2:0]     clock_sel;
  tpwm_count_type counter_value;
  tpwm_count_type compare_buffer;
  tpwm_count_type compare_value;
  tpwm_dir_type   count_dir;
  logic           compare_output;
  logic           overflow_flag;
  logic           compare_match_flag;
  logic           match_block;
  logic [9:0]     prescale_count;
  logic           pin_enable;

  // Next values.
  tpwm_count_type next_count;
  tpwm_dir_type   next_dir;
  logic           next_output;
  logic [9:0]     prescale_mask;

  // Bus decode.
  wire              access_first = psel_in & penable_in & ~pready_out;
  wire              commit       = psel_in & penable_in & pready_out;
  wire              wr_commit    = commit & pwrite_in;
  wire [ADDR_W-1:0] ofs_ctrl     = ADDR_W'(`TPWM_OFS_CTRL);
  wire [ADDR_W-1:0] ofs_count    = ADDR_W'(`TPWM_OFS_COUNT);
  wire [ADDR_W-1:0] ofs_cmp      = ADDR_W'(`TPWM_OFS_CMP);
  wire [ADDR_W-1:0] ofs_flags    = ADDR_W'(`TPWM_OFS_FLAGS);
  wire [ADDR_W-1:0] ofs_active   = ADDR_W'(`TPWM_OFS_ACTIVE);
  wire              hit_ctrl     = paddr_in == ofs_ctrl;
  wire              hit_count    = paddr_in == ofs_count;
  wire              hit_cmp      = paddr_in == ofs_cmp;
  wire              hit_flags    = paddr_in == ofs_flags;
  wire              hit_active   = paddr_in == ofs_active;
  wire              addr_hit     = hit_ctrl | hit_count | hit_cmp | hit_flags | hit_active;
  wire              wr_ctrl_lo   = wr_commit & hit_ctrl & pstrb_in[0];
  wire              wr_ctrl_hi   = wr_commit & hit_ctrl & pstrb_in[1];
  wire              wr_count     = wr_commit & hit_count & pstrb_in[0];
  wire              wr_cmp       = wr_commit & hit_cmp & pstrb_in[0];
  wire              wr_flags     = wr_commit & hit_flags & pstrb_in[0];

  wire [31:0] rd_ctrl   = {21'h000000, clock_sel, 2'h0, compare_output_mode,
                           2'h0, waveform_mode_sel};
  wire [31:0] rd_count  = {24'h000000, counter_value};
  wire [31:0] rd_cmp    = {24'h000000, compare_buffer};
  wire [31:0] rd_flags  = {30'h00000000, compare_match_flag, overflow_flag};
  wire [31:0] rd_active = {23'h000000, count_dir == dir_down, compare_value};
  wire [31:0] rd_mux    = hit_ctrl   ? rd_ctrl   :
                          hit_count  ? rd_count  :
                          hit_cmp    ? rd_cmp    :
                          hit_flags  ? rd_flags  :
                          hit_active ? rd_active : 32'h00000000;

  // Mode and counter decode.
  // mode decode
  wire mode_fast  = waveform_mode_sel == `TPWM_WGM_FAST;
  wire mode_pc    = waveform_mode_sel == `TPWM_WGM_PCPWM;
  wire mode_pwm   = mode_fast | mode_pc;
  wire at_max     = counter_value == `TPWM_MAX;
  wire at_bottom  = counter_value == `TPWM_BOTTOM;
  wire match      = (counter_value == compare_value) & ~match_block;
  wire com_pwm    = compare_output_mode[1];
  wire com_invert = compare_output_mode == `TPWM_COM_SET;
  wire com_toggle = compare_output_mode == `TPWM_COM_TOGGLE;
  wire com_off    = compare_output_mode == `TPWM_COM_OFF;
  wire cmp_src_max = compare_buffer == `TPWM_MAX;

  always_comb begin
    case (clock_sel)
      3'h1:    prescale_mask = `TPWM_PSC_MASK_1;
      3'h2:    prescale_mask = `TPWM_PSC_MASK_8;
      3'h3:    prescale_mask = `TPWM_PSC_MASK_32;
      3'h4:    prescale_mask = `TPWM_PSC_MASK_64;
      3'h5:    prescale_mask = `TPWM_PSC_MASK_128;
      3'h6:    prescale_mask = `TPWM_PSC_MASK_256;
      3'h7:    prescale_mask = `TPWM_PSC_MASK_1024;
      default: prescale_mask = `TPWM_PSC_MASK_1;
    endcase
  end

  wire timer_tick = (clock_sel != `TPWM_CS_STOP) &
                    ((prescale_count & prescale_mask) == prescale_mask);
  wire tick_run   = timer_tick & ~wr_count;

  wire ovf_event  = tick_run & (mode_pc ? at_bottom : at_max);
  wire cmf_event  = tick_run & match;
  wire cmp_load   = tick_run & mode_pwm & at_max;

  always_comb begin
    next_count = counter_value + 8'h01;
    next_dir   = dir_up;
    case (waveform_mode_sel)
      `TPWM_WGM_FAST: begin
        next_count = at_max ? `TPWM_BOTTOM : counter_value + 8'h01;
      end
      `TPWM_WGM_PCPWM: begin
        next_dir = count_dir;
        if (count_dir == dir_up) begin
          if (at_max) begin
            next_count = `TPWM_MAX - 8'h01;
            next_dir   = dir_down;
          end else begin
            next_count = counter_value + 8'h01;
          end
        end else begin
          if (at_bottom) begin
            next_count = `TPWM_BOTTOM + 8'h01;
            next_dir   = dir_up;
          end else begin
            next_count = counter_value - 8'h01;
          end
        end
      end
      `TPWM_WGM_CTC: begin
        next_count = match ? `TPWM_BOTTOM : counter_value + 8'h01;
      end
      default: begin
        next_count = counter_value + 8'h01;
      end
    endcase
  end

  // Compare output waveform.
  always_comb begin
    next_output = compare_output;
    if (tick_run && !com_off) begin
      if (mode_fast) begin
        if (com_pwm) begin
          if (at_max) begin
            next_output = ~com_invert;
          end else if (match) begin
            next_output = com_invert;
          end
        end else if (match) begin
          next_output = ~compare_output;
        end
      end else if (mode_pc) begin
        if (com_pwm) begin
          if (at_max) begin
            next_output = cmp_src_max ? ~com_invert : com_invert;
          end else if (match) begin
            if (count_dir == dir_up || at_bottom) begin
              next_output = com_invert;
            end else begin
              next_output = ~com_invert;
            end
          end
        end
      end else if (match) begin
        if (com_toggle) begin
          next_output = ~compare_output;
        end else begin
          next_output = com_invert;
        end
      end
    end
  end

  // APB slave answer, one wait state.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h00000000;
    end else begin
      pready_out  <= access_first;
      pslverr_out <= access_first & ~addr_hit;
      if (access_first) begin
        prdata_out <= pwrite_in ? 32'h00000000 : rd_mux;
      end
    end
  end

  // Control fields.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      waveform_mode_sel   <= `TPWM_WGM_RST;
      compare_output_mode <= `TPWM_COM_RST;
      clock_sel           <= `TPWM_CS_RST;
    end else begin
      if (wr_ctrl_lo) begin
        waveform_mode_sel   <= pwdata_in[`TPWM_CTRL_WGM_LSB +: 2];
        compare_output_mode <= pwdata_in[`TPWM_CTRL_COM_LSB +: 2];
      end
      if (wr_ctrl_hi) begin
        clock_sel <= pwdata_in[`TPWM_CTRL_CS_LSB +: 3];
      end
    end
  end

  // Prescaler runs freely on the system clock.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      prescale_count <= `TPWM_PSC_RST;
    end else begin
      prescale_count <= prescale_count + 10'h001;
    end
  end

  // Counter, direction and match blocking after a count write.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      counter_value <= `TPWM_COUNT_RST;
      count_dir     <= dir_up;
      match_block   <= 1'b0;
    end else if (wr_count) begin
      counter_value <= pwdata_in[7:0];
      match_block   <= 1'b1;
    end else if (tick_run) begin
      counter_value <= next_count;
      count_dir     <= next_dir;
      match_block   <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      compare_buffer <= `TPWM_CMP_RST;
      compare_value  <= `TPWM_CMP_RST;
    end else begin
      if (wr_cmp) begin
        compare_buffer <= pwdata_in[7:0];
      end
      if (wr_cmp && !mode_pwm) begin
        compare_value <= pwdata_in[7:0];
      end else if (cmp_load) begin
        compare_value <= compare_buffer;
      end
    end
  end

  // Sticky flags; an event in the clearing cycle wins.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      overflow_flag      <= 1'b0;
      compare_match_flag <= 1'b0;
    end else begin
      overflow_flag      <= ovf_event |
                            (overflow_flag & ~(wr_flags & pwdata_in[`TPWM_FLAG_OVF_BIT]));
      compare_match_flag <= cmf_event |
                            (compare_match_flag & ~(wr_flags & pwdata_in[`TPWM_FLAG_CMP_BIT]));
    end
  end

  // Output compare state and pin override.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      compare_output <= 1'b0;
      pin_enable     <= 1'b0;
    end else begin
      compare_output <= next_output;
      pin_enable     <= ~com_off;
    end
  end

  assign compare_output_out     = compare_output;
  assign compare_output_en_out  = pin_enable;
  assign overflow_flag_out      = overflow_flag;
  assign compare_match_flag_out = compare_match_flag;
  assign counter_value_out      = counter_value;

endmodule : tpwm_top

//--- tb/tpwm_asserts.sv
// Port checker of the PWM timer: bus answer, counter steps, flags, pin enable.
// Assumes it is bound into tpwm_top and sees only that module's ports.
`timescale 1ns/100ps
module tpwm_asserts #(
  parameter int ADDR_W = 12
) (
  input wire logic              clk_sys_in,
  input wire logic              rst_in,
  input wire logic              psel_in,
  input wire logic              penable_in,
  input wire logic              pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0]       pwdata_in,
  input wire logic [3:0]        pstrb_in,
  input wire logic [31:0]       prdata_out,
  input wire logic              pready_out,
  input wire logic              pslverr_out,
  input wire logic              compare_output_en_out,
  input wire logic              overflow_flag_out,
  input wire logic              compare_match_flag_out,
  input wire logic [7:0]        counter_value_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);
  wire logic done = psel_in & penable_in & pready_out;
  wire logic wr   = done & pwrite_in;
  wire logic fwr  = wr & pstrb_in[0] & (paddr_in == 12'h00C);
  wire logic cwr  = wr & pstrb_in[0] & (paddr_in == 12'h000);
  property p_ready_lat;
    $rose(penable_in) && psel_in |=> pready_out;
  endproperty
  a_ready_lat: assert property (p_ready_lat) else $error("late ready");
  property p_unmapped;
    done && paddr_in > 12'h010 |-> pslverr_out && prdata_out == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("no error");
  property p_count_step;
    !$past(wr) && counter_value_out != $past(counter_value_out) |->
      counter_value_out == $past(counter_value_out) + 8'h01 ||
      counter_value_out == $past(counter_value_out) - 8'h01;
  endproperty
  a_count_step: assert property (p_count_step) else $error("bad step");
  property p_wrap_ovf;
    !$past(wr) && $past(counter_value_out) == 8'hFF && counter_value_out == 8'h00
      |-> overflow_flag_out;
  endproperty
  a_wrap_ovf: assert property (p_wrap_ovf) else $error("no ovf at wrap");
  property p_bottom_ovf;
    !$past(wr) && !$past(wr, 2) && $past(counter_value_out, 2) == 8'h01 &&
      $past(counter_value_out) == 8'h00 && counter_value_out == 8'h01 |-> overflow_flag_out;
  endproperty
  a_bottom_ovf: assert property (p_bottom_ovf) else $error("no ovf");
  property p_ovf_sticky;
    $fell(overflow_flag_out) |-> $past(fwr && pwdata_in[0]);
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("ovf lost");
  property p_cmf_sticky;
    $fell(compare_match_flag_out) |-> $past(fwr && pwdata_in[1]);
  endproperty
  a_cmf_sticky: assert property (p_cmf_sticky) else $error("match lost");
  property p_en_lag;
    cwr |-> ##2 compare_output_en_out == $past(pwdata_in[5:4] != 2'h0, 2);
  endproperty
  a_en_lag: assert property (p_en_lag) else $error("bad enable");
endmodule : tpwm_asserts

bind tpwm_top tpwm_asserts #(.ADDR_W(ADDR_W)) i_tpwm_asserts (.clk_sys_in, .rst_in,
  .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pstrb_in, .prdata_out,
  .pready_out, .pslverr_out, .compare_output_en_out, .overflow_flag_out,
  .compare_match_flag_out, .counter_value_out);

//--- tb/tb.sv
// Self-checking bench of the PWM timer: bus, waveforms, flags and prescaler.
// Assumes tpwm_top with its checker bound in, one clock, synchronous reset.
`timescale 1ns/100ps
module tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        sel = 1'b0;
  logic        en = 1'b0;
  logic        wr = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [31:0] prdata, rdata;
  logic        rdy, serr, rerr, oc, oc_en, ovf, cmf;
  logic [7:0]  cnt;
  int          fails = 0;
  int          comparisons = 0;
  int          seed = 63;
  int          hi;

  always #2 clk = ~clk;

  tpwm_top #(.ADDR_W(12)) i_tpwm_top (.clk_sys_in(clk), .rst_in(rst), .psel_in(sel),
    .penable_in(en), .pwrite_in(wr), .paddr_in(addr), .pwdata_in(wdata),
    .pstrb_in(4'hF), .prdata_out(prdata), .pready_out(rdy), .pslverr_out(serr),
    .compare_output_out(oc), .compare_output_en_out(oc_en), .overflow_flag_out(ovf),
    .compare_match_flag_out(cmf), .counter_value_out(cnt));

  task automatic report_and_stop();
    if (fails == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    sel <= 1'b1;
    wr <= w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    en <= 1'b1;
    do begin
      @(posedge clk);
    end while (rdy !== 1'b1);
    rdata = prdata;
    rerr = serr;
    sel <= 1'b0;
    en <= 1'b0;
  endtask : apb

  task automatic setup(input logic [1:0] m, input logic [1:0] c, input logic [2:0] s,
                       input logic [7:0] v);
    apb(1'b1, 12'h008, {24'h0, v});
    apb(1'b1, 12'h004, 32'h0);
    apb(1'b1, 12'h000, {21'h0, s, 2'h0, c, 2'h0, m});
  endtask : setup

  task automatic wait_cnt(input logic [7:0] v);
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (cnt !== v && k < 3000);
    if (k >= 3000) fails++;
  endtask : wait_cnt

  task automatic duty(input int len);
    hi = 0;
    repeat (len) begin
      @(posedge clk);
      if (oc === 1'b1) hi++;
    end
  endtask : duty

  task automatic step_len(output int g);
    logic [7:0] c0;
    c0 = cnt;
    g = 0;
    do begin
      @(posedge clk);
      g++;
    end while (cnt === c0 && g < 2100);
  endtask : step_len

  function automatic int exp_hi(input logic [1:0] m, input logic [1:0] c, input int v);
    int h;
    if (m == 2'h1) h = 2 * v;
    else if (c == 2'h1) h = 256;
    else h = 2 * (v + 1);
    if (c == 2'h3) h = ((m == 2'h1) ? 510 : 512) - h;
    return h;
  endfunction : exp_hi

  function automatic int div(input int s);
    int t[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
    return t[s];
  endfunction : div

  initial begin
    #(4 * 60000);
    fails++;
    report_and_stop();
  end

  initial begin
    logic [1:0] m;
    logic [7:0] v;
    int         g;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    check({20'h0, oc, oc_en, ovf, cmf, cnt}, 32'h0);
    for (int a = 0; a < 24; a += 4) begin
      apb(1'b0, a[11:0], 32'h0);
      check({rerr, rdata[30:0]}, {a == 20, 31'h0});
    end
    setup(2'h3, 2'h0, 3'h1, 8'h40);
    repeat (600) @(posedge clk);
    duty(512);
    check({oc_en, hi[30:0]}, 32'h0);
    for (int mi = 0; mi < 2; mi++) begin
      for (int c = 1; c < 4; c++) begin
        for (int j = 0; j < 3; j++) begin
          m = (mi == 0) ? 2'h3 : 2'h1;
          v = (j == 0) ? 8'h00 : (j == 1) ? 8'hFF : 8'($random(seed));
          if (m == 2'h1 && c == 1) continue;
          setup(m, c[1:0], 3'h1, v);
          repeat (600) @(posedge clk);
          duty((m == 2'h1) ? 510 : 512);
          check(hi, exp_hi(m, c[1:0], v));
          apb(1'b0, 12'h00C, 32'h0);
          check(rdata, 32'h3);
          check({30'h0, cmf, ovf}, 32'h3);
          apb(1'b1, 12'h00C, 32'h3);
        end
      end
    end
    for (int s = 1; s < 8; s++) begin
      setup(2'h3, 2'h2, s[2:0], 8'h80);
      repeat (2) step_len(g);
      step_len(g);
      check(g, div(s));
    end
    setup(2'h1, 2'h2, 3'h1, 8'hFF);
    repeat (600) @(posedge clk);
    check({31'h0, oc}, 32'h1);
    apb(1'b1, 12'h008, 32'h40);
    wait_cnt(8'hFF);
    @(posedge clk);
    check({cnt, 23'h0, oc}, {8'hFE, 24'h0});
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    apb(1'b1, 12'h008, 32'h40);
    apb(1'b0, 12'h010, 32'h0);
    check(rdata & 32'hFF, 32'h40);
    apb(1'b1, 12'h004, 32'h80);
    apb(1'b1, 12'h000, 32'h131);
    wait_cnt(8'hFF);
    @(posedge clk);
    check({31'h0, oc}, 32'h1);
    apb(1'b1, 12'h000, 32'h3);
    apb(1'b1, 12'h008, 32'h90);
    apb(1'b0, 12'h010, 32'h0);
    check(rdata & 32'hFF, 32'h40);
    apb(1'b1, 12'h000, 32'h123);
    repeat (300) @(posedge clk);
    apb(1'b0, 12'h010, 32'h0);
    check(rdata & 32'hFF, 32'h90);
    report_and_stop();
  end
endmodule : tb
